// [swc_checker.sv]
// port checks for swc_top
// assumes a bind by port name
`timescale 1ns/1ns
`default_nettype none
`include "swc_defines.svh"
module swc_checker (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic STOP_REQ,
  input wire logic CLOCK_RUN,
  input wire logic WARM_START,
  input wire logic IN_STOP,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PRDATA
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  wire logic acc = PSEL && PENABLE;
  wire logic hit = (PADDR == `SWC_ADDR_CONFIG);
  a_rdy_on: assert property (PSEL |-> PREADY) else $error("ready");
  a_err_miss: assert property (acc && !hit |-> PSLVERR) else $error("err");
  a_err_hit: assert property (acc && hit |-> !PSLVERR) else $error("err");
  a_read_warm: assert property (acc && hit && !PWRITE |->
    PRDATA == {24'h0, WARM_START, 7'h0}) else $error("read");
  a_stop_in: assert property (CLOCK_RUN && STOP_REQ |=> IN_STOP) else $error("stop");
  a_run_excl: assert property (CLOCK_RUN |-> !IN_STOP) else $error("run");
  a_warm_hold: assert property (WARM_START |=> WARM_START) else $error("warm");
  a_warm_set: assert property ($rose(WARM_START) |-> $past(IN_STOP)) else $error("warm");
  cover property ($rose(WARM_START));
  cover property (acc && PSLVERR);
  cover property ($fell(IN_STOP));
endmodule
bind swc_top swc_checker swc_checker_i (.*);
`default_nettype wire

// [swc_defines.svh]
// constants for the stop-mode wake control block
// assumes inclusion by bare name from design and bench files
`ifndef SWC_DEFINES_SVH
`define SWC_DEFINES_SVH
`define SWC_IDX_CONFIG 12'h00B
// byte address: one aligned word per register, four times the index
`define SWC_ADDR_CONFIG (`SWC_IDX_CONFIG * 12'h004)
`define SWC_BIT_WARM 7
`define SWC_BIT_LEVEL 6
`define SWC_BIT_DELAY 5
`define SWC_SRC_HI 4
`define SWC_SRC_LO 2
`define SWC_SRC_NONE 3'h0
`define SWC_SRC_RSVD 3'h1
`define SWC_SRC_PIN_A 3'h2
`define SWC_SRC_PIN_B 3'h3
`define SWC_SRC_PIN_C 3'h4
`define SWC_SRC_PIN_D 3'h5
`define SWC_SRC_NOR4 3'h6
`define SWC_SRC_NOR8 3'h7
`define SWC_RST_DELAY 1'b1
`define SWC_RST_LEVEL 1'b0
`define SWC_RST_SRC 3'h0
`define SWC_CLK_NS 20
`define SWC_STARTUP_NS 5000000
`endif

// [swc_pins.sv]
// wake source model
// assumes go is a one-cycle pulse
`timescale 1ns/1ns
`default_nettype none
module swc_pins (
  input wire logic CLK_SYS, go, lvl,
  input wire logic [2:0] src,
  output logic [3:0] pin,
  output logic [7:0] PORT2_IN
);
  logic [2:0] n_q = 3'h0;
  wire logic a = n_q != 3'h0;
  // five cycles, the shortest hold a fast wake allows
  always @(posedge CLK_SYS) n_q <= go ? 3'h5 : n_q - 3'(a);
  assign pin = {4{!lvl}} ^ ({4{a}} & (4'h1 << (src - 3'h2)));
  assign PORT2_IN = a ? {7'h0, !lvl} : {8{lvl}};
endmodule
`default_nettype wire

// [swc_pkg.sv]
// types for the stop-mode wake control block
// assumes swc_defines.svh is on the include path
package swc_pkg;
  typedef struct packed {
    logic level_high;
    logic use_delay;
    logic [2:0] source;
  } swc_cfg_t;
  typedef enum logic [1:0] {
    SWC_RUN,
    SWC_STOP,
    SWC_DELAY
  } swc_state_t;
endpackage

// [swc_tb_top.sv]
// bench for swc_top
// assumes swc_pins and the bound checker
`timescale 1ns/1ns
`default_nettype none
`include "swc_defines.svh"
module swc_tb_top;
  logic CLK_SYS = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, STOP_REQ = 0, go = 0;
  logic lvl = 0, l, d, x, PREADY, PSLVERR, CLOCK_RUN, WARM_START, IN_STOP;
  logic [2:0] src = 0, c;
  logic [3:0] pin;
  logic [7:0] PORT2_IN, PORT2_OUT_EN = 0;
  logic [11:0] PADDR = 0;
  logic [31:0] PWDATA = 0, PRDATA;
  int n_mismatch = 0, checked = 0, seed = 32'hB23E, i, k;
  always #10 CLK_SYS = ~CLK_SYS;
  swc_top #(.STARTUP_CYCLES(8)) swc_top_i (.*, .WAKE_PIN_A(pin[0]), .WAKE_PIN_B(pin[1]),
    .WAKE_PIN_C(pin[2]), .WAKE_PIN_D(pin[3]));
  swc_pins swc_pins_i (.*);
  task report_and_stop;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] g, e);
    checked++;
    if (g !== e || k == 30) begin
      n_mismatch++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
    if (k == 30) report_and_stop;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] v, r);
    {PSEL, PWRITE, PADDR, PWDATA} <= {1'b1, w, a, v};
    @(posedge CLK_SYS);
    PENABLE <= 1;
    k = 0;
    do @(posedge CLK_SYS); while (PREADY !== 1 && ++k < 30);
    chk({PSLVERR, w ? 31'h0 : PRDATA[30:0]}, r);
    {PSEL, PENABLE} <= 0;
    @(posedge CLK_SYS);
  endtask
  task wk(input logic s);
    STOP_REQ <= 1;
    @(posedge CLK_SYS);
    {STOP_REQ, go} <= 2'b01;
    @(posedge CLK_SYS);
    go <= 0;
    for (k = 0; k < 30 && CLOCK_RUN !== 1; k++) @(negedge CLK_SYS);
    if (!x) k = 0;
    chk({WARM_START, CLOCK_RUN, k > 6}, {x, x, s & x});
    @(posedge CLK_SYS);
  endtask
  initial begin
    repeat (10) @(posedge CLK_SYS);
    RST_N <= 1;
    @(posedge CLK_SYS);
    apb(0, `SWC_ADDR_CONFIG, 0, 0);
    apb(1, 12'h0FF, 32'hFF, 32'h80000000);
    // refused codes and a nor4 wake on a masked output pin first, while the warm flag is still clear
    for (i = 0; i < 9; i++) begin
      x = i > 2;
      // the bench clock is no crystal, so a clear delay bit is legal
      {l, d} = 2'($random(seed));
      l = l & x;
      c = (i == 2) ? 3'h6 : 3'(x ? i - 1 : i);
      {src, lvl, PORT2_OUT_EN} <= {c, l, 7'h0, !x};
      apb(1, `SWC_ADDR_CONFIG, {25'h0, l, d, c, 2'h0}, 0);
      wk(d);
      if (x) apb(0, `SWC_ADDR_CONFIG, 0, 32'h80);
      if (x) wk(d);
      RST_N <= x;
      @(posedge CLK_SYS);
      RST_N <= 1;
      @(posedge CLK_SYS);
    end
    report_and_stop;
  end
endmodule
`default_nettype wire

// [swc_top.sv]
// stop-mode wake control: config register over apb, wake watch, startup delay
// assumes core asserts STOP_REQ to enter stop and a cold reset drives RST_N low
// limitation: a pin transition is taken as a level, sampled once per clock
// the config register answers at four times its index on the bus
// software is trusted to keep the delay bit set behind a crystal
//
// Contract
// - three-bit source code selects wake pin
// - codes 110/111 wake on port 2 NOR
// - port 2 outputs forced to default level
// - delay bit low skips startup delay
// - level bit chooses active high or low
// - warm flag set on recovery, else cleared
// - bits 6..2 write-only, bit 7 read-only
// - config survives stop recovery, reset on cold
`timescale 1ns/1ns
`default_nettype none
`include "swc_defines.svh"

module swc_top #(
  parameter int unsigned STARTUP_CYCLES = `SWC_STARTUP_NS / `SWC_CLK_NS
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic STOP_REQ,
  input wire logic WAKE_PIN_A,
  input wire logic WAKE_PIN_B,
  input wire logic WAKE_PIN_C,
  input wire logic WAKE_PIN_D,
  input wire logic [7:0] PORT2_IN,
  input wire logic [7:0] PORT2_OUT_EN,
  output logic CLOCK_RUN,
  output logic WARM_START,
  output logic IN_STOP
);

  localparam int unsigned CW = $clog2(STARTUP_CYCLES + 1);

  // ****************************************
  // register access
  // ****************************************
  swc_pkg::swc_cfg_t cfg_q;
  swc_pkg::swc_cfg_t cfg_d;
  swc_pkg::swc_state_t state_q;
  logic warm_q;
  logic [CW-1:0] cnt_q;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic hit;
  logic setup_any;
  logic setup_rd;
  logic wr_acc;

  // whole-word match; the register sits at four times its index
  function automatic logic reg_hit(input logic [11:0] addr);
    reg_hit = (addr == `SWC_ADDR_CONFIG);
  endfunction

  assign hit = reg_hit(PADDR);
  assign setup_any = PSEL && !PENABLE;
  assign setup_rd = setup_any && !PWRITE && hit;
  assign wr_acc = PSEL && PENABLE && PWRITE && hit;
  // zero wait states: every access ends in its first access cycle
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !hit;

  // write-only fields; the bus cannot read them back
  always_comb begin
    cfg_d = cfg_q;
    if (wr_acc) begin
      cfg_d.level_high = PWDATA[`SWC_BIT_LEVEL];
      cfg_d.use_delay = PWDATA[`SWC_BIT_DELAY];
      cfg_d.source = PWDATA[`SWC_SRC_HI:`SWC_SRC_LO];
    end
  end

  // cold reset only; stop recovery never touches this register
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      cfg_q.use_delay <= `SWC_RST_DELAY;
      cfg_q.level_high <= `SWC_RST_LEVEL;
      cfg_q.source <= `SWC_RST_SRC;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // captured in setup so it stands through the access phase
  always_comb begin
    prdata_d = prdata_q;
    if (setup_rd) begin
      prdata_d = 32'h0;
      prdata_d[`SWC_BIT_WARM] = warm_q;
    end else if (setup_any) begin
      prdata_d = 32'h0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      prdata_q <= 32'h0;
    end else begin
      prdata_q <= prdata_d;
    end
  end
  assign PRDATA = prdata_q;

  // ****************************************
  // wake source selection
  // ****************************************
  // output lines read as the inactive default so only inputs steer the nor
  function automatic logic [7:0] p2_eff(input logic [7:0] pin, input logic [7:0] oe);
    p2_eff = pin & ~oe;
  endfunction

  logic [7:0] p2;
  logic src_raw;
  logic wake;
  assign p2 = p2_eff(PORT2_IN, PORT2_OUT_EN);

  always_comb begin
    case (cfg_q.source)
      `SWC_SRC_PIN_A: src_raw = WAKE_PIN_A;
      `SWC_SRC_PIN_B: src_raw = WAKE_PIN_B;
      `SWC_SRC_PIN_C: src_raw = WAKE_PIN_C;
      `SWC_SRC_PIN_D: src_raw = WAKE_PIN_D;
      `SWC_SRC_NOR4: src_raw = ~|p2[3:0];
      `SWC_SRC_NOR8: src_raw = ~|p2;
      default: src_raw = !cfg_q.level_high; // none/reserved never wake
    endcase
  end
  assign wake = (src_raw == cfg_q.level_high);

  // ****************************************
  // stop sequencing
  // ****************************************
  swc_pkg::swc_state_t state_d;
  logic [CW-1:0] cnt_d;
  logic warm_d;

  // wake is looked at only while stopped
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      swc_pkg::SWC_RUN: begin
        if (STOP_REQ) begin
          state_d = swc_pkg::SWC_STOP;
        end
      end
      swc_pkg::SWC_STOP: begin
        if (wake) begin
          if (cfg_q.use_delay) begin
            state_d = swc_pkg::SWC_DELAY;
            cnt_d = CW'(STARTUP_CYCLES - 1);
          end else begin
            // one sampled cycle suffices; the five-period hold is the source's duty
            state_d = swc_pkg::SWC_RUN;
          end
        end
      end
      swc_pkg::SWC_DELAY: begin
        // count the startup delay down, run again at zero
        if (cnt_q == '0) begin
          state_d = swc_pkg::SWC_RUN;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      default: begin
        state_d = swc_pkg::SWC_RUN;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      state_q <= swc_pkg::SWC_RUN;
      cnt_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // leaving stop sets the flag; only a cold reset clears it
  always_comb begin
    warm_d = warm_q;
    if (state_q == swc_pkg::SWC_STOP && wake) begin
      warm_d = 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      warm_q <= 1'b0;
    end else begin
      warm_q <= warm_d;
    end
  end

  // ****************************************
  // status outputs
  // ****************************************
  // the startup delay counts as stopped: the core clock stays off
  assign CLOCK_RUN = (state_q == swc_pkg::SWC_RUN);
  assign IN_STOP = (state_q != swc_pkg::SWC_RUN);
  assign WARM_START = warm_q;
  // crystal users must leave use_delay set; not enforced here

endmodule
`default_nettype wire
